// ---- shared/uatx_regs.svh ----
// register offsets, field positions, reset values and timing counts of the transmitter
`ifndef UATX_REGS_SVH
`define UATX_REGS_SVH
// word offsets on the bus (byte addresses)
`define UATX_OFS_IRQ_MASTER   8'h00
`define UATX_OFS_FLAGS        8'h04
`define UATX_OFS_ENABLES      8'h08
`define UATX_OFS_PRIORITY     8'h0c
`define UATX_OFS_RX_CTRL      8'h10
`define UATX_OFS_HOLD         8'h14
`define UATX_OFS_TX_CTRL      8'h18
`define UATX_OFS_DIVISOR      8'h1c
// field positions
`define UATX_BIT_CLK_SRC      7
`define UATX_BIT_NINE         6
`define UATX_BIT_TXON         5
`define UATX_BIT_SYNC         4
`define UATX_BIT_HISPEED      2
`define UATX_BIT_SHIFT_EMPTY  1
`define UATX_BIT_NINTH        0
`define UATX_BIT_PORT_ON      7
`define UATX_BIT_TXFLAG       4
// writable masks of the registers with read-only bits; priority uses the enables mask, hold and divisor have none
`define UATX_MASK_TX_CTRL     8'hf5
`define UATX_MASK_IRQ_MASTER  8'hc0
`define UATX_MASK_FLAGS       8'h21
`define UATX_MASK_ENABLES     8'h31
`define UATX_MASK_RX_CTRL     8'hf8
// reset values
`define UATX_RST_REG          8'h00
// prescale factors
`define UATX_PRESCALE_LO      7'd64
`define UATX_PRESCALE_HI      7'd16
// cycles from holding-buffer load until flag read is valid
`define UATX_FLAG_SETTLE      2'd2
`endif

// ---- shared/uatx_pkg.sv ----
// types shared by the transmitter files
package uatx_pkg;
    // bus request of a classic wishbone cycle
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } uatx_wb_req_s;
    // bus answer
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } uatx_wb_rsp_s;
    // transmitter states
    typedef enum logic [1:0] {
        UATX_IDLE,
        UATX_LOAD,
        UATX_SHIFT
    } uatx_state_e;
    // baud tick generator state
    typedef struct packed {
        logic [7:0] div_cnt;
        logic [6:0] pre_cnt;
        logic       tick;
    } uatx_baud_s;
    // shifter state
    typedef struct packed {
        uatx_state_e state;
        logic [10:0] shift;
        logic [3:0]  bits_left;
        logic        line;
        logic        taken;
    } uatx_shift_s;
endpackage

// ---- hdl/uatx_baud.sv ----
// baud tick generator: divisor counter then prescaler
`timescale 1ns/10ps
`include "uatx_regs.svh"
module uatx_baud (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic       hispeed_i,
    input  wire logic [7:0] divisor_i,
    output logic            tick_o
);
    import uatx_pkg::*;
    uatx_baud_s r;       // registered state
    uatx_baud_s next_r;  // next state
    logic [6:0] pre_top; // prescale terminal count

    // next state: one tick per prescale*(divisor+1) cycles
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        // sixteen or sixty-four per bit
        pre_top = hispeed_i ? `UATX_PRESCALE_HI - 7'd1 : `UATX_PRESCALE_LO - 7'd1;
        if (!run_i) begin
            // hold still when idle so each frame starts aligned
            next_r.div_cnt = 8'h00;
            next_r.pre_cnt = 7'h00;
        end else if (r.div_cnt >= divisor_i) begin
            // eight-bit divider wraps
            next_r.div_cnt = 8'h00;
            if (r.pre_cnt >= pre_top) begin
                next_r.pre_cnt = 7'h00;
                next_r.tick = 1'b1;
            end else begin
                next_r.pre_cnt = r.pre_cnt + 7'd1;
            end
        end else begin
            next_r.div_cnt = r.div_cnt + 8'd1;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick_o = r.tick;

    // tick never two cycles running, since prescale is sixteen or sixty-four
    a_tick_single : assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |=> !tick_o) else $error("baud tick repeated");
    // tick needs run
    a_tick_run : assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |-> $past(run_i)) else $error("tick while stopped");
endmodule

// ---- hdl/uatx_shifter.sv ----
// frame shifter: start bit, data lsb first, optional ninth bit, stop bit
`timescale 1ns/10ps
module uatx_shifter (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic       tick_i,
    input  wire logic       pending_i,
    input  wire logic       nine_i,
    input  wire logic [8:0] data_i,
    output logic            take_o,
    output logic            empty_o,
    output logic            busy_o,
    output logic            line_o
);
    import uatx_pkg::*;
    uatx_shift_s r;      // registered state
    uatx_shift_s next_r; // next state

    // frame sequencing
    always_comb begin
        next_r = r;
        next_r.taken = 1'b0;
        case (r.state)
            UATX_IDLE: begin
                next_r.line = 1'b1; // mark while idle
                // reload only when no frame is in flight
                if (enable_i && pending_i) begin
                    next_r.state = UATX_LOAD;
                end
            end
            UATX_LOAD: begin
                // one cycle handoff from buffer
                next_r.taken = 1'b1;
                // stop, ninth, data, start; shifted out lsb first
                if (nine_i) begin
                    next_r.shift = {1'b1, data_i[8], data_i[7:0], 1'b0};
                    next_r.bits_left = 4'd11;
                end else begin
                    next_r.shift = {1'b1, 1'b1, data_i[7:0], 1'b0};
                    next_r.bits_left = 4'd10;
                end
                next_r.state = UATX_SHIFT;
            end
            default: begin
                if (!enable_i) begin
                    // disabling aborts and returns to mark
                    next_r.state = UATX_IDLE;
                    next_r.line = 1'b1;
                end else if (tick_i) begin
                    if (r.bits_left == 4'd0) begin
                        // stop bit finished
                        next_r.state = pending_i ? UATX_LOAD : UATX_IDLE;
                        next_r.line = 1'b1;
                    end else begin
                        next_r.line = r.shift[0];
                        next_r.shift = {1'b1, r.shift[10:1]};
                        next_r.bits_left = r.bits_left - 4'd1;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{state: UATX_IDLE, shift: 11'h7ff, bits_left: 4'h0, line: 1'b1,
                   taken: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // handoff is the load cycle itself, so a bus load in that cycle is kept
    assign take_o  = (r.state == UATX_LOAD);
    assign empty_o = (r.state == UATX_IDLE);
    assign busy_o  = (r.state != UATX_IDLE);
    assign line_o  = r.line;

    // idle line at mark
    a_idle_mark : assert property (@(posedge clk_i) disable iff (rst_i)
        (r.state == UATX_IDLE) && $past(r.state == UATX_IDLE) |-> line_o)
        else $error("idle line not mark");
    // first tick of frame drives start bit low
    a_start_low : assert property (@(posedge clk_i) disable iff (rst_i)
        (r.state == UATX_SHIFT) && enable_i && tick_i
        && (r.bits_left == (nine_i ? 4'd11 : 4'd10)) |=> !line_o)
        else $error("start bit missing");
    // load lasts exactly one cycle
    a_load_one : assert property (@(posedge clk_i) disable iff (rst_i)
        (r.state == UATX_LOAD) |=> (r.state == UATX_SHIFT) && r.taken)
        else $error("handoff not one cycle");
    c_frame_end : cover property (@(posedge clk_i) disable iff (rst_i)
        (r.state == UATX_SHIFT) ##1 (r.state == UATX_IDLE));
    c_back_back : cover property (@(posedge clk_i) disable iff (rst_i)
        (r.state == UATX_SHIFT) ##1 (r.state == UATX_LOAD));
endmodule

// ---- hdl/uatx_top.sv ----
// asynchronous serial transmitter with wishbone register file
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "uatx_regs.svh"
module uatx_top (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [7:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic               ack_o,
    output logic [31:0]        dat_o,
    output logic               tx_o,
    output logic               irq_o
);
    import uatx_pkg::*;

    // all registered state of the top
    typedef struct packed {
        logic [7:0] master;
        logic [7:0] flags_sw;
        logic [7:0] enables;
        logic [7:0] priority_r;
        logic [7:0] rx_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] divisor;
        logic [7:0] hold;
        logic       hold_full;
        logic       txon_d;
        logic [1:0] settle;
        logic       ack;
        logic [31:0] rdat;
    } uatx_top_s;

    uatx_top_s r;       // registered state
    uatx_top_s next_r;  // next state
    logic tick;         // baud tick
    logic take;         // shifter took the buffer
    logic sh_empty;     // shifter empty
    logic sh_busy;      // frame in flight
    logic sh_line;      // shifter line level
    logic tx_run;       // transmitter may run
    logic flag;         // buffer-empty flag as read
    logic wr_acc;       // write access taken this cycle
    logic rd_acc;       // read access taken this cycle

    // map an address to its writable mask; all ones for unmapped
    function automatic logic [7:0] wmask(input logic [7:0] a);
        if (a == `UATX_OFS_IRQ_MASTER) begin
            wmask = `UATX_MASK_IRQ_MASTER;
        end else if (a == `UATX_OFS_ENABLES) begin
            wmask = `UATX_MASK_ENABLES;
        end else if (a == `UATX_OFS_PRIORITY) begin
            wmask = `UATX_MASK_ENABLES;
        end else if (a == `UATX_OFS_RX_CTRL) begin
            wmask = `UATX_MASK_RX_CTRL;
        end else if (a == `UATX_OFS_TX_CTRL) begin
            wmask = `UATX_MASK_TX_CTRL;
        end else if (a == `UATX_OFS_FLAGS) begin
            wmask = `UATX_MASK_FLAGS;
        end else begin
            wmask = 8'hff;
        end
    endfunction

    // asynchronous mode with port on and transmit on
    assign tx_run = r.rx_ctrl[`UATX_BIT_PORT_ON] && r.tx_ctrl[`UATX_BIT_TXON]
                    && !r.tx_ctrl[`UATX_BIT_SYNC];
    // flag reads set until settle passes after a load
    assign flag = !r.hold_full || (r.settle != 2'd0);
    assign wr_acc = cyc_i && stb_i && we_i && !r.ack && (sel_i[0] == 1'b1);
    assign rd_acc = cyc_i && stb_i && !we_i && !r.ack;

    // shared baud generator
    uatx_baud u_baud (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (sh_busy),
        .hispeed_i (r.tx_ctrl[`UATX_BIT_HISPEED]),
        .divisor_i (r.divisor),
        .tick_o    (tick)
    );

    // frame shifter, not addressable from the bus
    uatx_shifter u_shift (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .enable_i  (tx_run),
        .tick_i    (tick),
        .pending_i (r.hold_full && !take && r.txon_d), // no start while enabling discards
        .nine_i    (r.tx_ctrl[`UATX_BIT_NINE]),
        .data_i    ({r.tx_ctrl[`UATX_BIT_NINTH], r.hold}),
        .take_o    (take),
        .empty_o   (sh_empty),
        .busy_o    (sh_busy),
        .line_o    (sh_line)
    );

    // register file and buffer bookkeeping
    always_comb begin
        next_r = r;
        next_r.ack = cyc_i && stb_i && !r.ack;
        next_r.txon_d = r.tx_ctrl[`UATX_BIT_TXON];
        if (r.settle != 2'd0) begin
            next_r.settle = r.settle - 2'd1;
        end
        // handoff empties the buffer, setting the flag
        if (take) begin
            next_r.hold_full = 1'b0;
        end
        // enabling the transmitter empties buffer, flag set
        if (r.tx_ctrl[`UATX_BIT_TXON] && !r.txon_d) begin
            next_r.hold_full = 1'b0;
        end
        if (wr_acc) begin
            if (adr_i == `UATX_OFS_HOLD) begin
                // load clears flag, valid two cycles later
                next_r.hold = dat_i[7:0];
                next_r.hold_full = 1'b1;
                next_r.settle = `UATX_FLAG_SETTLE;
            end else if (adr_i == `UATX_OFS_TX_CTRL) begin
                // shifter-empty bit is read only
                next_r.tx_ctrl = dat_i[7:0] & wmask(adr_i);
            end else if (adr_i == `UATX_OFS_IRQ_MASTER) begin
                next_r.master = dat_i[7:0] & wmask(adr_i);
            end else if (adr_i == `UATX_OFS_FLAGS) begin
                // buffer-empty flag not writable
                next_r.flags_sw = dat_i[7:0] & wmask(adr_i);
            end else if (adr_i == `UATX_OFS_ENABLES) begin
                next_r.enables = dat_i[7:0] & wmask(adr_i);
            end else if (adr_i == `UATX_OFS_PRIORITY) begin
                next_r.priority_r = dat_i[7:0] & wmask(adr_i);
            end else if (adr_i == `UATX_OFS_RX_CTRL) begin
                next_r.rx_ctrl = dat_i[7:0] & wmask(adr_i);
            end else if (adr_i == `UATX_OFS_DIVISOR) begin
                next_r.divisor = dat_i[7:0];
            end
        end
        // read mux; unimplemented bits and unmapped addresses give zero
        next_r.rdat = 32'h0000_0000;
        if (rd_acc) begin
            if (adr_i == `UATX_OFS_IRQ_MASTER) begin
                next_r.rdat[7:0] = r.master;
            end else if (adr_i == `UATX_OFS_FLAGS) begin
                next_r.rdat[7:0] = r.flags_sw;
                next_r.rdat[`UATX_BIT_TXFLAG] = flag;
            end else if (adr_i == `UATX_OFS_ENABLES) begin
                next_r.rdat[7:0] = r.enables;
            end else if (adr_i == `UATX_OFS_PRIORITY) begin
                next_r.rdat[7:0] = r.priority_r;
            end else if (adr_i == `UATX_OFS_RX_CTRL) begin
                next_r.rdat[7:0] = r.rx_ctrl;
            end else if (adr_i == `UATX_OFS_HOLD) begin
                next_r.rdat[7:0] = r.hold;
            end else if (adr_i == `UATX_OFS_TX_CTRL) begin
                next_r.rdat[7:0] = r.tx_ctrl;
                next_r.rdat[`UATX_BIT_SHIFT_EMPTY] = sh_empty;
            end else if (adr_i == `UATX_OFS_DIVISOR) begin
                next_r.rdat[7:0] = r.divisor;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign ack_o = r.ack;
    assign dat_o = r.rdat;
    // mark when disabled, no hardware parity on the line
    assign tx_o  = tx_run ? sh_line : 1'b1;
    // enable only gates the request, with both master enables
    assign irq_o = flag && r.enables[`UATX_BIT_TXFLAG]
                   && r.master[7] && r.master[6];

    // flag reads set for two cycles after a load
    a_flag_settle : assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_acc && adr_i == `UATX_OFS_HOLD) |=> flag [*2])
        else $error("flag cleared too early");
    // handoff sets the flag
    a_take_flag : assert property (@(posedge clk_i) disable iff (rst_i)
        take && !(wr_acc && adr_i == `UATX_OFS_HOLD) |=> flag)
        else $error("flag not set after handoff");
    // enabling sets the flag
    a_txon_flag : assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(r.tx_ctrl[`UATX_BIT_TXON]) && !(wr_acc && adr_i == `UATX_OFS_HOLD)
        |=> flag) else $error("enable did not set flag");
    // line idles at mark when disabled
    a_off_mark : assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_run |-> tx_o ##1 sh_line) else $error("line active while off");
    // ack is a one-cycle pulse
    a_ack_pulse : assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held");
    // unmapped read returns zero
    a_unmapped_zero : assert property (@(posedge clk_i) disable iff (rst_i)
        rd_acc && adr_i > `UATX_OFS_DIVISOR |=> dat_o == 32'h0)
        else $error("unmapped nonzero");
    // upper read bits always zero
    a_upper_zero : assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits set");
    // shifter empty reflected on read
    a_empty_read : assert property (@(posedge clk_i) disable iff (rst_i)
        rd_acc && adr_i == `UATX_OFS_TX_CTRL |=>
        dat_o[`UATX_BIT_SHIFT_EMPTY] == $past(sh_empty)) else $error("empty bit wrong");
    // irq needs enable
    a_irq_gate : assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> r.enables[`UATX_BIT_TXFLAG]) else $error("irq without enable");
    c_load : cover property (@(posedge clk_i) disable iff (rst_i)
        wr_acc && adr_i == `UATX_OFS_HOLD);
    c_irq : cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
    c_take : cover property (@(posedge clk_i) disable iff (rst_i) take);
endmodule

// ---- verification/uatx_rx_model.sv ----
// serial receiver model that watches the transmit line
`timescale 1ns/10ps
module uatx_rx_model (
    input  wire logic       clk_i,
    input  wire logic       line_i,
    input  wire logic       nine_i,
    input  int              bit_i,
    output logic [8:0]      frame_o,
    output logic            stop_ok_o,
    output int              count_o
);
    logic [8:0] acc;  // data bits gathered so far
    int         n;    // data bits in this frame

    // hunt for a start bit, then sample each cell in its middle
    initial begin
        frame_o = 9'h000;
        stop_ok_o = 1'b0;
        count_o = 0;
        forever begin
            @(posedge clk_i);
            if (line_i === 1'b0) begin  // start bit found
                acc = 9'h000;
                n = nine_i ? 9 : 8;  // ninth bit when selected
                repeat (bit_i / 2 - 1) @(posedge clk_i);
                for (int i = 0; i < n; i++) begin  // least significant first
                    repeat (bit_i) @(posedge clk_i);
                    acc[i] = line_i;
                end
                repeat (bit_i) @(posedge clk_i);
                stop_ok_o <= line_i;  // one stop bit at mark
                frame_o <= acc;
                count_o <= count_o + 1;
            end
        end
    end
endmodule

// ---- verification/uart_async_transmitter_tb.sv ----
// register-level bench of the transmitter with a line receiver model
`timescale 1ns/10ps
`include "uatx_regs.svh"
module uart_async_transmitter_tb;
    import uatx_pkg::*;
    logic        clk_i;       // 200 mhz clock
    logic        rst_i;       // synchronous reset
    logic        wb_cyc;      // bus cycle
    logic        wb_stb;      // bus strobe
    logic        wb_we;       // bus direction
    logic [7:0]  wb_adr;      // bus address
    logic [31:0] wb_dat;      // bus write data
    logic        ack;         // bus answer
    logic [31:0] dat;         // bus read data
    logic        tx;          // serial line
    logic        irq;         // interrupt request
    logic [31:0] rd;          // last read value
    logic [8:0]  frame;       // last received frame
    logic        stop_ok;     // stop bit level
    logic        nine;        // receiver frame length
    int          count;       // frames received
    int          bit_len;     // cycles per bit
    int          mismatches;  // failed checks
    int          num_checks;  // checks made

    uatx_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(wb_cyc), .stb_i(wb_stb),
                    .we_i(wb_we), .adr_i(wb_adr), .sel_i(4'hf), .dat_i(wb_dat),
                    .ack_o(ack), .dat_o(dat), .tx_o(tx), .irq_o(irq));
    uatx_rx_model i_peer (.clk_i(clk_i), .line_i(tx), .nine_i(nine), .bit_i(bit_len),
                          .frame_o(frame), .stop_ok_o(stop_ok), .count_o(count));

    // free-running clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // verdict and end of run
    task results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a wait that ran out
    task timeout;
        mismatches++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        results();
    endtask

    // classic single bus cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) timeout();
        rd = dat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // read and compare
    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask

    // wait for a frame at the receiver and compare it
    task wait_frame(input logic [8:0] exp, input int want, input int limit);
        int n;
        n = 0;
        while (count < want && n < limit) begin
            @(posedge clk_i);
            n++;
        end
        if (count < want) timeout();
        chk({23'h0, frame}, {23'h0, exp});
        chk({31'h0, stop_ok}, 32'h1);
    endtask

    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h18};
    logic [7:0] msk [7] = '{8'hc0, 8'h31, 8'h31, 8'h31, 8'hf8, 8'hff, 8'hf7};

    // main sequence
    initial begin
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_dat = 32'h0;
        nine = 1'b0;
        bit_len = 16;
        mismatches = 0;
        num_checks = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, tx}, 32'h1);  // idle at mark
        for (int i = 0; i < 8; i++) begin  // buffer and shifter both empty after reset
            rdchk(8'(i * 4), (i == 6) ? 8'h02 : ((i == 1) ? 8'h10 : 8'h00));
        end
        rdchk(8'h20, 8'h00);  // unmapped place
        for (int i = 0; i < 7; i++) begin  // writable bits and set status bits only, others zero
            wb(1'b1, ofs[i], 8'hff);
            rdchk(ofs[i], msk[i]);
            wb(1'b1, ofs[i], 8'h00);
        end
        wb(1'b1, 8'h04, 8'h00);
        rdchk(8'h04, 8'h10);  // flag set by transmit-on, not cleared by write
        wb(1'b1, 8'h08, 8'h10);
        wb(1'b1, 8'h00, 8'hc0);  // global and peripheral enables
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h08, 8'h00);
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rdchk(8'h04, 8'h10);  // flag stands without its enable
        wb(1'b1, 8'h08, 8'h10);
        wb(1'b1, 8'h14, 8'h77);  // load while transmit off stays in the buffer
        repeat (2) @(posedge clk_i);  // no poll right after a load
        rdchk(8'h04, 8'h00);  // load clears the flag
        chk({31'h0, irq}, 32'h0);  // no request while the flag is clear
        wb(1'b1, 8'h1c, 8'h00);  // divisor then mode, port on
        wb(1'b1, 8'h10, 8'h80);
        wb(1'b1, 8'h18, 8'h24);  // async, high speed, transmit on
        rdchk(8'h04, 8'h10);  // rising transmit-on empties the buffer
        wb(1'b1, 8'h14, 8'ha5);  // starts the first frame
        wb(1'b1, 8'h14, 8'h5a);
        repeat (4) @(posedge clk_i);  // no poll right after a load
        rdchk(8'h04, 8'h00);  // buffer full while shifter busy
        chk({31'h0, irq}, 32'h0);
        rdchk(8'h18, 8'h24);  // shifter not empty
        wait_frame(9'h0a5, 1, 12 * bit_len);
        repeat (bit_len) @(posedge clk_i);  // handoff comes once the stop bit ends
        rdchk(8'h04, 8'h10);  // handoff after stop bit
        wait_frame(9'h05a, 2, 11 * bit_len);  // one mark bit between frames
        repeat (16) @(posedge clk_i);
        rdchk(8'h18, 8'h26);  // shifter empty again
        wb(1'b1, 8'h18, 8'h65);  // nine bits, ninth bit one
        nine = 1'b1;
        wb(1'b1, 8'h14, 8'h3c);
        wait_frame(9'h13c, 3, 13 * bit_len);
        wb(1'b1, 8'h1c, 8'h01);  // slow prescale, divisor one
        wb(1'b1, 8'h18, 8'h60);
        bit_len = 128;
        wb(1'b1, 8'h14, 8'h81);
        wait_frame(9'h081, 4, 14 * bit_len);
        wb(1'b1, 8'h14, 8'h00);
        repeat (200) @(posedge clk_i);
        wb(1'b1, 8'h18, 8'h70);  // clocked-mode bit set mid-frame
        repeat (2) @(posedge clk_i);
        chk({31'h0, tx}, 32'h1);  // line back at mark
        results();
    end
endmodule
